// ===== bench/rfid_cfg_checker.sv
// port assertions for the protocol configuration block
// assumes a bind from the bench and one clock domain
`timescale 1ns/1ps
`include "rfid_cfg_params.svh"
////////////////////////////////////////////////////////////
module rfid_cfg_checker
#(
  parameter int unsigned NORESP_STEP_CYCLES = 4
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic chip_enable,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and outputs
  input wire logic tx_pulse_start,
  input wire logic slot_start,
  input wire logic tag_response_start,
  input wire logic mod_pulse,
  input wire logic irq,
  input wire logic rx_crc_absent,
  input wire logic direct_variant,
  input wire logic high_rate,
  input wire logic double_subcarrier,
  input wire logic one_of_256
);
  logic [11:0] hi_reg, hi_next;
  wire logic [5:0] idx = paddr[7:2];
  wire logic mapped = idx == `CFG_IDX_PROTOCOL || idx == `CFG_IDX_PULSE || idx == `CFG_IDX_NORESP
    || idx == `CFG_IDX_IRQ_STATUS || idx == `CFG_IDX_IRQ_MASK;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // length of the running pulse, bounded by the longest override
  always_comb hi_next = mod_pulse ? hi_reg + 12'h001 : 12'h000;
  always_ff @(posedge clock) hi_reg <= hi_next;
  ////////////////////////////////////////////////////////////
  // apb answer timing and error reporting
  ready_timing_a:
    assert property (psel && penable && !pready |=> pready) else $error("pready late");
  ready_once_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_cause_a:
    assert property (!(psel && penable) |=> !pready) else $error("pready without request");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a:
    assert property (psel && penable && !pready && !mapped |=> pslverr) else $error("no error on hole");
  mapped_ok_a:
    assert property (pready && mapped |-> !pslverr) else $error("error on mapped register");
  write_rdata_a:
    assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
  read_upper_a:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  // modulation pulse start and length limits
  pulse_start_a:
    assert property (tx_pulse_start && !mod_pulse |=> mod_pulse) else $error("pulse not started");
  pulse_min_a:
    assert property ($rose(mod_pulse) |-> mod_pulse [*7]) else $error("pulse too short");
  pulse_max_a:
    assert property (hi_reg <= 12'h757) else $error("pulse too long");
endmodule

// ===== bench/tb.sv
// self-checking bench for the protocol configuration block
// assumes the design, package, header and checker are compiled first
`timescale 1ns/1ps
module tb;
  import rfid_cfg_pkg::*;
  typedef struct packed {logic [7:0] wr; logic [4:0] dec; logic [7:0] nr;} row_t;
  logic clock = 0, resetn = 0, chip_enable = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_pulse_start = 0, slot_start = 0, tag_response_start = 0;
  logic mod_pulse, irq, rx_crc_absent, direct_variant, high_rate, double_subcarrier, one_of_256;
  int n_errors = 0, n_compared = 0, cycles = 0, cnt;
  int plen [3] = '{1, 255, 0};
  // bit 5 kept clear in every row 0x47 sets bit 6 ahead of direct mode
  row_t rows [8] = '{'{8'h00, 5'h00, 8'h30}, '{8'h01, 5'h01, 8'h30}, '{8'h02, 5'h04, 8'h14},
    '{8'h03, 5'h05, 8'h14}, '{8'h04, 5'h02, 8'h30}, '{8'h05, 5'h03, 8'h30},
    '{8'h86, 5'h16, 8'h14}, '{8'h47, 5'h0f, 8'h14}};
  wire logic [4:0] dec = {rx_crc_absent, direct_variant, high_rate, double_subcarrier, one_of_256};

  rfid_protocol_config_timers #(.NORESP_STEP_CYCLES(4)) dut
  (
    .clock(clock), .resetn(resetn), .chip_enable(chip_enable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_pulse_start(tx_pulse_start), .slot_start(slot_start), .tag_response_start(tag_response_start),
    .mod_pulse(mod_pulse), .irq(irq), .rx_crc_absent(rx_crc_absent), .direct_variant(direct_variant),
    .high_rate(high_rate), .double_subcarrier(double_subcarrier), .one_of_256(one_of_256)
  );
  ////////////////////////////////////////////////////////////
  always #5 clock = ~clock;
  // hang guard, far beyond the few thousand cycles needed
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict;
    end
  end
  task print_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task check_rst;
    rdc(8'h04, 32'h02);
    rdc(8'h18, 32'h00);
    rdc(8'h1c, 32'h0e);
    rdc(8'h30, 32'h00);
    check(dec, 5'h04);
  endtask
  // slot with wait 1: flag and irq after 4+2 cycles
  task slot(input logic cancel);
    @(posedge clock);
    slot_start <= 1;
    cnt = 0;
    do
    begin
      @(posedge clock);
      slot_start <= 0;
      tag_response_start <= cancel && cnt == 1;
      cnt++;
    end
    while (irq !== 1'b1 && cnt < 30);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clock);
    resetn <= 1;
    repeat (4) @(posedge clock);
    check_rst;
    foreach (rows[i])
    begin
      // dirty both preset targets so a missing preset shows
      wr(8'h18, 32'h55);
      wr(8'h1c, 32'h55);
      wr(8'h04, rows[i].wr);
      rdc(8'h04, rows[i].wr);
      rdc(8'h18, 32'h00);
      rdc(8'h1c, rows[i].nr);
      check(dec, rows[i].dec);
    end
    apb(1'b0, 8'h08, 32'h0);
    check(err, 1'b1);
    wr(8'h34, 32'h3);
    foreach (plen[i])
    begin
      wr(8'h18, plen[i]);
      @(posedge clock);
      tx_pulse_start <= 1;
      cnt = 0;
      @(posedge clock);
      tx_pulse_start <= 0;
      do
      begin
        @(posedge clock);
        if (mod_pulse === 1'b1)
          cnt++;
      end
      while (mod_pulse === 1'b1 || cnt == 0);
      check(cnt, plen[i] ? plen[i] * 73700 / 10000 : 944);
      check(irq, 1'b1);
      wr(8'h30, 32'h2);
    end
    wr(8'h1c, 32'h1);
    slot(1'b0);
    check(cnt, 7);
    rdc(8'h30, 32'h1);
    wr(8'h30, 32'h1);
    // the clear lands on the edge the task returns at; look one edge later
    @(posedge clock);
    check(irq, 1'b0);
    slot(1'b1);
    check(irq, 1'b0);
    wr(8'h34, 32'h0);
    slot(1'b0);
    check(irq, 1'b0);
    rdc(8'h30, 32'h1);
    chip_enable <= 0;
    repeat (4) @(posedge clock);
    chip_enable <= 1;
    repeat (4) @(posedge clock);
    check_rst;
    print_verdict;
  end
endmodule

bind rfid_protocol_config_timers rfid_cfg_checker #(.NORESP_STEP_CYCLES(NORESP_STEP_CYCLES)) chk
(
  .clock(clock), .resetn(resetn), .chip_enable(chip_enable),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_pulse_start(tx_pulse_start), .slot_start(slot_start), .tag_response_start(tag_response_start),
  .mod_pulse(mod_pulse), .irq(irq), .rx_crc_absent(rx_crc_absent), .direct_variant(direct_variant),
  .high_rate(high_rate), .double_subcarrier(double_subcarrier), .one_of_256(one_of_256)
);

// ===== common/rfid_cfg_params.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a word-indexed apb register map
`ifndef RFID_CFG_PARAMS_SVH
`define RFID_CFG_PARAMS_SVH

// register indices (byte address is four times the index)
`define CFG_IDX_PROTOCOL 6'h01
`define CFG_IDX_PULSE 6'h06
`define CFG_IDX_NORESP 6'h07
`define CFG_IDX_IRQ_STATUS 6'h0c
`define CFG_IDX_IRQ_MASK 6'h0d

// protocol select field positions
`define CFG_BIT_RX_CRC_ABSENT 7
`define CFG_BIT_DIRECT_VARIANT 6
`define CFG_BIT_RESERVED 5
`define CFG_BIT_DOUBLE_SUB 2
`define CFG_BIT_HIGH_RATE 1
`define CFG_BIT_ONE_OF_256 0

// irq status and mask field positions
`define CFG_BIT_IRQ_NORESP 0
`define CFG_BIT_IRQ_PULSE_DONE 1

// reset values
`define CFG_RST_PROTOCOL 8'h02
`define CFG_RST_PULSE 8'h00
`define CFG_RST_NORESP 8'h0e
`define CFG_RST_IRQ_MASK 8'h00

// presets loaded on a protocol write
`define CFG_PRESET_PULSE 8'h00
`define CFG_PRESET_NORESP_HIGH 8'h14
`define CFG_PRESET_NORESP_LOW 8'h30

// timing, in picoseconds and nanoseconds as printed
`define CFG_CLK_PERIOD_PS 10000
`define CFG_CLK_PERIOD_NS 10
`define CFG_PULSE_STEP_PS 73700
`define CFG_PROTO_PULSE_PS 9440000
`define CFG_NORESP_STEP_NS 37760
`define CFG_NORESP_STEP_CYCLES (`CFG_NORESP_STEP_NS / `CFG_CLK_PERIOD_NS)

`endif

// ===== common/rfid_cfg_pkg.sv
// types shared by the configuration block and its slot timer
// assumes nothing beyond a systemverilog compiler
package rfid_cfg_pkg;

  // modulation pulse generator states
  typedef enum logic [0:0]
  {
    PULSE_IDLE = 1'b0,
    PULSE_ACTIVE = 1'b1
  } pulse_state_t;

  // empty-slot timer states
  typedef enum logic [0:0]
  {
    SLOT_IDLE = 1'b0,
    SLOT_RUN = 1'b1
  } slot_state_t;

  typedef logic [7:0] cfg_byte_t;

endpackage

// ===== common/slot_timer_if.sv
// carrier between the configuration block and its empty-slot timer
// assumes both ends run on the same system clock
`timescale 1ns/1ps

interface slot_timer_if;
  logic start;
  logic cancel;
  logic [7:0] wait_steps;
  logic expired;
  logic busy;

  // configuration side
  modport ctrl
  (
    output start,
    output cancel,
    output wait_steps,
    input expired,
    input busy
  );

  // timer side
  modport timer
  (
    input start,
    input cancel,
    input wait_steps,
    output expired,
    output busy
  );
endinterface

// ===== src/rfid_protocol_config_timers.sv
// protocol configuration registers, pulse-length and empty-slot timing
// assumes an apb master on the system clock and an asynchronous chip enable pin
`timescale 1ns/1ps
`include "rfid_cfg_params.svh"

module rfid_protocol_config_timers
  import rfid_cfg_pkg::*;
#(
  parameter int unsigned NORESP_STEP_CYCLES = `CFG_NORESP_STEP_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // chip enable pin, asynchronous
  input wire logic chip_enable,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framing events, same clock
  input wire logic tx_pulse_start,
  input wire logic slot_start,
  input wire logic tag_response_start,
  // modulation and interrupt
  output logic mod_pulse,
  output logic irq,
  // decoded protocol selection
  output logic rx_crc_absent,
  output logic direct_variant,
  output logic high_rate,
  output logic double_subcarrier,
  output logic one_of_256
);
  import rfid_cfg_pkg::*;

  localparam logic [24:0] STEP_PS = 25'(`CFG_PULSE_STEP_PS);
  localparam logic [24:0] PROTO_PS = 25'(`CFG_PROTO_PULSE_PS);
  localparam logic [24:0] CLK_PS = 25'(`CFG_CLK_PERIOD_PS);

  logic en_meta_reg;
  logic en_sync_reg;
  logic run_n;
  cfg_byte_t protocol_reg, protocol_next;
  cfg_byte_t pulse_reg, pulse_next;
  cfg_byte_t noresp_reg, noresp_next;
  logic [1:0] status_reg, status_next;
  logic [1:0] mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  pulse_state_t pstate_reg, pstate_next;
  logic [24:0] elapsed_reg, elapsed_next;
  logic [24:0] target_reg, target_next;
  logic pulse_done;
  logic [5:0] index;
  logic mapped;
  logic wr_commit;
  logic [31:0] rd_value;

  slot_timer_if slot_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // chip enable synchroniser; enable low acts as a reset of the block
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end
    else
    begin
      en_meta_reg <= chip_enable;
      en_sync_reg <= en_meta_reg;
    end
  end

  assign run_n = resetn & en_sync_reg;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode; word index, byte address is four times the index
  assign index = paddr[7:2];
  assign mapped = (index == `CFG_IDX_PROTOCOL) || (index == `CFG_IDX_PULSE) ||
                  (index == `CFG_IDX_NORESP) || (index == `CFG_IDX_IRQ_STATUS) ||
                  (index == `CFG_IDX_IRQ_MASK);
  // a write lands only at the edge where the master sees pready
  assign wr_commit = psel && penable && pwrite && pready_reg && mapped;

  // read mux, narrow registers sit in the low bits
  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (index)
      `CFG_IDX_PROTOCOL: rd_value = {24'h00_0000, protocol_reg};
      `CFG_IDX_PULSE: rd_value = {24'h00_0000, pulse_reg};
      `CFG_IDX_NORESP: rd_value = {24'h00_0000, noresp_reg};
      `CFG_IDX_IRQ_STATUS: rd_value = {30'h0000_0000, status_reg};
      `CFG_IDX_IRQ_MASK: rd_value = {30'h0000_0000, mask_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_comb
  begin
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel && penable && !pready_reg)
    begin
      pready_next = 1'b1;
      pslverr_next = !mapped;
      prdata_next = (pwrite || !mapped) ? 32'h0000_0000 : rd_value;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers and their presets
  always_comb
  begin
    protocol_next = protocol_reg;
    pulse_next = pulse_reg;
    noresp_next = noresp_reg;
    mask_next = mask_reg;
    if (wr_commit)
    begin
      unique case (index)
        `CFG_IDX_PROTOCOL:
        begin
          // reserved bit 5 is stored as written; the host keeps it zero
          protocol_next = pwdata[7:0];
          // presets land on the write edge, ready for the next access
          pulse_next = `CFG_PRESET_PULSE;
          noresp_next = pwdata[`CFG_BIT_HIGH_RATE] ? `CFG_PRESET_NORESP_HIGH
                                                   : `CFG_PRESET_NORESP_LOW;
        end
        `CFG_IDX_PULSE: pulse_next = pwdata[7:0];
        `CFG_IDX_NORESP: noresp_next = pwdata[7:0];
        `CFG_IDX_IRQ_MASK: mask_next = pwdata[1:0];
        default: mask_next = mask_reg;
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_comb
  begin
    status_next = status_reg;
    if (wr_commit && index == `CFG_IDX_IRQ_STATUS)
    begin
      status_next = status_reg & ~pwdata[1:0];
    end
    status_next[`CFG_BIT_IRQ_NORESP] = status_next[`CFG_BIT_IRQ_NORESP] | slot_bus.expired;
    status_next[`CFG_BIT_IRQ_PULSE_DONE] = status_next[`CFG_BIT_IRQ_PULSE_DONE] | pulse_done;
    irq_next = |(status_next & mask_next);
  end

  //////////////////////////////////////////////////////////////////////////////
  // modulation pulse: length in picoseconds, advanced one clock period a cycle
  always_comb
  begin
    pstate_next = pstate_reg;
    elapsed_next = elapsed_reg;
    target_next = target_reg;
    pulse_done = 1'b0;
    unique case (pstate_reg)
      PULSE_IDLE:
      begin
        if (tx_pulse_start)
        begin
          pstate_next = PULSE_ACTIVE;
          elapsed_next = CLK_PS;
          // override of zero falls back to the protocol pulse
          target_next = (pulse_reg == 8'h00) ? PROTO_PS
                                             : 25'(pulse_reg * STEP_PS);
        end
      end
      PULSE_ACTIVE:
      begin
        // truncates to whole clocks: a step is 7.37 periods
        if (elapsed_reg + CLK_PS > target_reg)
        begin
          pstate_next = PULSE_IDLE;
          pulse_done = 1'b1;
        end
        else
        begin
          elapsed_next = elapsed_reg + CLK_PS;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // empty-slot timer control
  assign slot_bus.start = slot_start;
  assign slot_bus.cancel = tag_response_start;
  assign slot_bus.wait_steps = noresp_reg;

  slot_timer #(
    .STEP_CYCLES(NORESP_STEP_CYCLES)
  ) u_slot_timer (
    .clock(clock),
    .run_n(run_n),
    .tmr(slot_bus.timer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb answer registers; enable low drops a transfer in flight
  always_ff @(posedge clock)
  begin
    if (!run_n)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // configuration registers; enable low or reset returns every default
  always_ff @(posedge clock)
  begin
    if (!run_n)
    begin
      protocol_reg <= `CFG_RST_PROTOCOL;
      pulse_reg <= `CFG_RST_PULSE;
      noresp_reg <= `CFG_RST_NORESP;
      mask_reg <= 2'(`CFG_RST_IRQ_MASK);
    end
    else
    begin
      protocol_reg <= protocol_next;
      pulse_reg <= pulse_next;
      noresp_reg <= noresp_next;
      mask_reg <= mask_next;
    end
  end

  // sticky status and the registered interrupt line
  always_ff @(posedge clock)
  begin
    if (!run_n)
    begin
      status_reg <= 2'b00;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // modulation pulse state; a pulse cut by enable low reports no done event
  always_ff @(posedge clock)
  begin
    if (!run_n)
    begin
      pstate_reg <= PULSE_IDLE;
      elapsed_reg <= 25'h000_0000;
      target_reg <= 25'h000_0000;
    end
    else
    begin
      pstate_reg <= pstate_next;
      elapsed_reg <= elapsed_next;
      target_reg <= target_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from registers
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign mod_pulse = (pstate_reg == PULSE_ACTIVE);
  assign rx_crc_absent = protocol_reg[`CFG_BIT_RX_CRC_ABSENT];
  // the host sets this before entering direct mode
  assign direct_variant = protocol_reg[`CFG_BIT_DIRECT_VARIANT];
  assign double_subcarrier = protocol_reg[`CFG_BIT_DOUBLE_SUB];
  assign high_rate = protocol_reg[`CFG_BIT_HIGH_RATE];
  assign one_of_256 = protocol_reg[`CFG_BIT_ONE_OF_256];
endmodule

// ===== src/slot_timer.sv
// empty-slot timer: counts wait_steps steps of a fixed cycle count
// assumes start and cancel come from logic on the same clock
`timescale 1ns/1ps
`include "rfid_cfg_params.svh"

module slot_timer
  import rfid_cfg_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `CFG_NORESP_STEP_CYCLES
)
(
  // clock and synchronous reset
  input wire logic clock,
  input wire logic run_n,
  // control carrier
  slot_timer_if.timer tmr
);
  import rfid_cfg_pkg::*;

  localparam int unsigned PW = $clog2(STEP_CYCLES + 1);

  slot_state_t state_reg, state_next;
  logic [PW-1:0] pre_reg, pre_next;
  logic [7:0] steps_reg, steps_next;
  logic expired_reg, expired_next;

  //////////////////////////////////////////////////////////////////////////////
  // next state: prescale to steps, count steps down
  always_comb
  begin
    state_next = state_reg;
    pre_next = pre_reg;
    steps_next = steps_reg;
    expired_next = 1'b0;
    if (tmr.start && tmr.wait_steps != 8'h00)
    begin
      // a new slot restarts the wait even if one was running
      state_next = SLOT_RUN;
      pre_next = PW'(STEP_CYCLES - 1);
      steps_next = tmr.wait_steps;
    end
    else if (tmr.start || tmr.cancel)
    begin
      // zero wait disables the timer; a response ends the wait
      state_next = SLOT_IDLE;
    end
    else
    begin
      unique case (state_reg)
        SLOT_IDLE:
        begin
          state_next = SLOT_IDLE;
        end
        SLOT_RUN:
        begin
          if (pre_reg != '0)
          begin
            pre_next = pre_reg - PW'(1);
          end
          else if (steps_reg == 8'h01)
          begin
            state_next = SLOT_IDLE;
            expired_next = 1'b1;
          end
          else
          begin
            pre_next = PW'(STEP_CYCLES - 1);
            steps_next = steps_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge clock)
  begin
    if (!run_n)
    begin
      state_reg <= SLOT_IDLE;
      pre_reg <= '0;
      steps_reg <= 8'h00;
      expired_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      steps_reg <= steps_next;
      expired_reg <= expired_next;
    end
  end

  assign tmr.expired = expired_reg;
  assign tmr.busy = (state_reg == SLOT_RUN);
endmodule
